// *** verilog/lpm_pkg.sv ***
// shared constants and types of the light and proximity measurement command block
package lpm_pkg;
  localparam logic [6:0] LPM_DEV_ADDR = 7'h13;
  localparam logic [7:0] LPM_REG_FIRST = 8'h80;
  localparam logic [7:0] LPM_REG_LAST = 8'h90;
  localparam int LPM_NUM_REGS = 17;
  localparam logic [4:0] LPM_IDX_CMD = 5'h00;
  localparam logic [4:0] LPM_IDX_ID = 5'h01;
  localparam logic [4:0] LPM_IDX_ALS_HI = 5'h05;
  localparam logic [4:0] LPM_IDX_ALS_LO = 5'h06;
  localparam logic [4:0] LPM_IDX_PROX_HI = 5'h07;
  localparam logic [4:0] LPM_IDX_PROX_LO = 5'h08;
  localparam int LPM_CMD_ALS_RDY = 6;
  localparam int LPM_CMD_PROX_RDY = 5;
  localparam int LPM_CMD_ALS_OS = 4;
  localparam int LPM_CMD_PROX_OS = 3;
  localparam int LPM_CMD_ALS_PER = 2;
  localparam int LPM_CMD_PROX_PER = 1;
  localparam int LPM_CMD_RUN = 0;
  localparam logic LPM_CMD_LOCK_VAL = 1'b1;
  localparam int LPM_CH_ALS = 1;
  localparam int LPM_CH_PROX = 0;
  localparam logic [7:0] LPM_REG_RST = 8'h00;
  // identification value is arbitrary
  localparam logic [7:0] LPM_ID_VALUE = 8'h5a;
  localparam logic [3:0] LPM_BITS_BYTE = 4'h8;
  localparam logic [3:0] LPM_BIT_LAST = 4'h7;
  localparam int LPM_CLK_PERIOD_NS = 8;
  localparam int LPM_CONV_TIME_NS = 20000;
  localparam int LPM_CONV_CYC = (LPM_CONV_TIME_NS + LPM_CLK_PERIOD_NS - 1) / LPM_CLK_PERIOD_NS;
  localparam int LPM_CONV_W = 12;
  localparam int LPM_PERIOD_TIME_NS = 1000000;
  localparam int LPM_PERIOD_CYC = LPM_PERIOD_TIME_NS / LPM_CLK_PERIOD_NS;
  localparam int LPM_PERIOD_W = 20;

  typedef enum logic [2:0] {
    LPM_ST_IDLE = 3'b000,
    LPM_ST_ADDR = 3'b001,
    LPM_ST_PTR = 3'b010,
    LPM_ST_WDATA = 3'b011,
    LPM_ST_ACK = 3'b100,
    LPM_ST_RDATA = 3'b101,
    LPM_ST_MACK = 3'b110
  } lpm_i2c_state_type;

  function automatic logic lpm_in_range(input logic [7:0] addr);
    return (addr >= LPM_REG_FIRST) && (addr <= LPM_REG_LAST);
  endfunction : lpm_in_range

  function automatic logic [4:0] lpm_reg_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - LPM_REG_FIRST;
    return diff[4:0];
  endfunction : lpm_reg_index
endpackage : lpm_pkg

// *** verilog/lpm_reg_if.sv ***
// register access strobes between the serial slave and the register file
`timescale 1ns/1ps
interface lpm_reg_if;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : lpm_reg_if

// *** verilog/lpm_i2c_slave.sv ***
// serial two-wire slave with register pointer and auto increment
`timescale 1ns/1ps
module lpm_i2c_slave
  import lpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_s,
  input wire logic sda_s,
  output logic sda_oe,
  lpm_reg_if.bus rb
);
  lpm_i2c_state_type state_ff;
  lpm_i2c_state_type after_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic [3:0] cnt_ff;
  logic nack_ff;

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire rx_state = (state_ff == LPM_ST_ADDR) | (state_ff == LPM_ST_PTR) | (state_ff == LPM_ST_WDATA);
  wire byte_end = rx_state & scl_fall & (cnt_ff == LPM_BITS_BYTE);
  wire addr_hit = shift_ff[7:1] == LPM_DEV_ADDR;
  wire ack_fall = scl_fall & (state_ff == LPM_ST_ACK);
  wire load_tx = (ack_fall & (after_ff == LPM_ST_RDATA)) | (scl_fall & (state_ff == LPM_ST_MACK) & ~nack_ff);

  assign rb.wr_stb = byte_end & (state_ff == LPM_ST_WDATA);
  assign rb.rd_stb = load_tx;
  assign rb.addr = ptr_ff;
  assign rb.wdata = shift_ff;
  // only ever pulls low: acknowledge or a zero data bit
  assign sda_oe = (state_ff == LPM_ST_ACK) | ((state_ff == LPM_ST_RDATA) & ~tx_ff[7]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= LPM_ST_IDLE;
      after_ff <= LPM_ST_IDLE;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      shift_ff <= 8'h00;
      tx_ff <= 8'hff;
      ptr_ff <= 8'h00;
      cnt_ff <= 4'h0;
      nack_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (stop_c) begin
        state_ff <= LPM_ST_IDLE;
      end else if (start_c) begin
        state_ff <= LPM_ST_ADDR;
        cnt_ff <= 4'h0;
      end else begin
        if (rx_state & scl_rise) begin
          shift_ff <= {shift_ff[6:0], sda_s};
          cnt_ff <= cnt_ff + 4'h1;
        end
        if (byte_end) begin
          cnt_ff <= 4'h0;
          if (state_ff == LPM_ST_ADDR) begin
            state_ff <= addr_hit ? LPM_ST_ACK : LPM_ST_IDLE;
            after_ff <= shift_ff[0] ? LPM_ST_RDATA : LPM_ST_PTR;
          end else begin
            state_ff <= LPM_ST_ACK;
            after_ff <= LPM_ST_WDATA;
            ptr_ff <= (state_ff == LPM_ST_PTR) ? shift_ff : ptr_ff + 8'h01;
          end
        end
        if (ack_fall & (after_ff != LPM_ST_RDATA)) begin
          state_ff <= after_ff;
        end
        if (load_tx) begin
          tx_ff <= rb.rdata;
          ptr_ff <= ptr_ff + 8'h01;
          cnt_ff <= 4'h0;
          state_ff <= LPM_ST_RDATA;
        end
        if (scl_fall & (state_ff == LPM_ST_RDATA)) begin
          if (cnt_ff == LPM_BIT_LAST) begin
            state_ff <= LPM_ST_MACK;
          end else begin
            cnt_ff <= cnt_ff + 4'h1;
            tx_ff <= {tx_ff[6:0], 1'b1};
          end
        end
        if (scl_rise & (state_ff == LPM_ST_MACK)) begin
          nack_ff <= sda_s;
        end
        if (scl_fall & (state_ff == LPM_ST_MACK) & nack_ff) begin
          state_ff <= LPM_ST_IDLE;
        end
      end
    end
  end

  foreign_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    byte_end && (state_ff == LPM_ST_ADDR) && !addr_hit |=> state_ff == LPM_ST_IDLE && !sda_oe)
    else $error("foreign address was acknowledged");
  read_dir_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    byte_end && (state_ff == LPM_ST_ADDR) && addr_hit |=> after_ff == (shift_ff[0] ? LPM_ST_RDATA : LPM_ST_PTR))
    else $error("direction bit not honoured");
endmodule : lpm_i2c_slave

// *** verilog/lpm_meas_engine.sv ***
// conversion timers for both channels and the periodic measurement timer
`timescale 1ns/1ps
module lpm_meas_engine
  import lpm_pkg::*;
#(
  parameter int PERIOD_CYC = LPM_PERIOD_CYC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic run_en,
  input wire logic [1:0] per_en,
  input wire logic [1:0] os_start,
  output logic [1:0] busy,
  output logic [1:0] done
);
  logic [LPM_PERIOD_W-1:0] per_cnt_ff;
  logic [LPM_CONV_W-1:0] conv_cnt_ff [2];
  logic [1:0] busy_ff;
  logic [1:0] done_ff;

  wire per_run = run_en & |per_en;
  wire per_tick = per_run & (per_cnt_ff == '0);
  wire [1:0] go = ((per_tick ? per_en : 2'b00) | os_start) & ~busy_ff;
  assign busy = busy_ff;
  assign done = done_ff;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      per_cnt_ff <= '0;
    end else if (!per_run || per_cnt_ff == LPM_PERIOD_W'(PERIOD_CYC - 1)) begin
      per_cnt_ff <= '0;
    end else begin
      per_cnt_ff <= per_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 2'b00;
      done_ff <= 2'b00;
      conv_cnt_ff[0] <= '0;
      conv_cnt_ff[1] <= '0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        done_ff[ch] <= busy_ff[ch] && (conv_cnt_ff[ch] == LPM_CONV_W'(LPM_CONV_CYC - 1));
        if (go[ch]) begin
          busy_ff[ch] <= 1'b1;
          conv_cnt_ff[ch] <= '0;
        end else if (busy_ff[ch] && (conv_cnt_ff[ch] == LPM_CONV_W'(LPM_CONV_CYC - 1))) begin
          busy_ff[ch] <= 1'b0;
        end else if (busy_ff[ch]) begin
          conv_cnt_ff[ch] <= conv_cnt_ff[ch] + 1'b1;
        end
      end
    end
  end

  als_periodic_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    per_tick && per_en[LPM_CH_ALS] && !busy_ff[LPM_CH_ALS] |=> busy_ff[LPM_CH_ALS])
    else $error("periodic ambient measurement not started");
  prox_periodic_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    per_tick && per_en[LPM_CH_PROX] && !busy_ff[LPM_CH_PROX] |=> busy_ff[LPM_CH_PROX])
    else $error("periodic proximity measurement not started");
  run_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !run_en || per_en == 2'b00 |-> !per_tick)
    else $error("periodic start without run and channel enable");
endmodule : lpm_meas_engine

// *** verilog/lpm_measure_top.sv ***
// measurement command, status and register file of the light and proximity sensor
`timescale 1ns/1ps
module lpm_measure_top
  import lpm_pkg::*;
#(
  parameter int PERIOD_CYC = LPM_PERIOD_CYC
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic int_out,
  output logic int_oe,
  input wire logic [15:0] als_result,
  input wire logic [15:0] prox_result,
  output logic als_conv,
  output logic prox_conv
);
  lpm_reg_if rb ();

  logic scl_m_ff;
  logic scl_s_ff;
  logic sda_m_ff;
  logic sda_s_ff;
  logic run_ff;
  logic [1:0] per_en_ff;
  logic [1:0] os_ff;
  logic [1:0] rdy_ff;
  logic [15:0] als_res_ff;
  logic [15:0] prox_res_ff;
  logic [7:0] gen_ff [LPM_NUM_REGS];
  logic [1:0] nxt_os;
  logic [1:0] nxt_rdy;
  logic [1:0] busy;
  logic [1:0] done;
  logic [1:0] os_start;
  logic [1:0] os_req;
  logic [1:0] rd_clr;
  logic [7:0] cmd_value;
  logic [7:0] rd_data;

  // address decode
  wire in_range = lpm_in_range(rb.addr);
  wire [4:0] idx = lpm_reg_index(rb.addr);
  wire is_cmd = in_range && (idx == LPM_IDX_CMD);
  wire is_id = in_range && (idx == LPM_IDX_ID);
  wire is_als = in_range && ((idx == LPM_IDX_ALS_HI) || (idx == LPM_IDX_ALS_LO));
  wire is_prox = in_range && ((idx == LPM_IDX_PROX_HI) || (idx == LPM_IDX_PROX_LO));
  wire cmd_wr = rb.wr_stb && is_cmd;
  wire gen_wr = rb.wr_stb && in_range && !is_cmd && !is_id && !is_als && !is_prox;

  // pin synchronisers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
    end
  end

  // oversampled slave, fast enough for the high speed bit rate
  lpm_i2c_slave u_slave (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .scl_s(scl_s_ff),
    .sda_s(sda_s_ff),
    .sda_oe(sda_oe),
    .rb(rb.bus)
  );

  lpm_meas_engine #(
    .PERIOD_CYC(PERIOD_CYC)
  ) u_engine (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run_en(run_ff),
    .per_en(per_en_ff),
    .os_start(os_start),
    .busy(busy),
    .done(done)
  );

  assign sda_out = 1'b0;
  assign als_conv = busy[LPM_CH_ALS];
  assign prox_conv = busy[LPM_CH_PROX];

  // one-shot starts, dropped while the run bit is set or being set
  assign os_req = {rb.wdata[LPM_CMD_ALS_OS], rb.wdata[LPM_CMD_PROX_OS]}
                  & {2{cmd_wr && !rb.wdata[LPM_CMD_RUN] && !run_ff}};
  assign os_start = os_req & ~busy;
  assign nxt_os = (os_ff & ~done) | os_start;

  // ready flags: completion wins over a clearing read
  assign rd_clr = {rb.rd_stb && is_als, rb.rd_stb && is_prox};
  assign nxt_rdy = done | (rdy_ff & ~rd_clr);

  // open drain request: pulled low while a result waits
  assign int_out = 1'b0;
  assign int_oe = |rdy_ff;

  assign cmd_value = {LPM_CMD_LOCK_VAL, rdy_ff[LPM_CH_ALS], rdy_ff[LPM_CH_PROX],
                      os_ff[LPM_CH_ALS], os_ff[LPM_CH_PROX],
                      per_en_ff[LPM_CH_ALS], per_en_ff[LPM_CH_PROX], run_ff};

  // read selection
  assign rd_data = !in_range ? LPM_REG_RST :
                   is_cmd ? cmd_value :
                   is_id ? LPM_ID_VALUE :
                   (idx == LPM_IDX_ALS_HI) ? als_res_ff[15:8] :
                   (idx == LPM_IDX_ALS_LO) ? als_res_ff[7:0] :
                   (idx == LPM_IDX_PROX_HI) ? prox_res_ff[15:8] :
                   (idx == LPM_IDX_PROX_LO) ? prox_res_ff[7:0] :
                   gen_ff[idx];
  assign rb.rdata = rd_data;

  // command register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_ff <= 1'b0;
      per_en_ff <= 2'b00;
    end else if (cmd_wr) begin
      run_ff <= rb.wdata[LPM_CMD_RUN];
      per_en_ff <= {rb.wdata[LPM_CMD_ALS_PER], rb.wdata[LPM_CMD_PROX_PER]};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      os_ff <= 2'b00;
      rdy_ff <= 2'b00;
    end else begin
      os_ff <= nxt_os;
      rdy_ff <= nxt_rdy;
    end
  end

  // result capture at end of conversion
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      als_res_ff <= 16'h0000;
      prox_res_ff <= 16'h0000;
    end else begin
      if (done[LPM_CH_ALS]) begin
        als_res_ff <= als_result;
      end
      if (done[LPM_CH_PROX]) begin
        prox_res_ff <= prox_result;
      end
    end
  end

  // plain read/write parameter and setting registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < LPM_NUM_REGS; i++) begin
        gen_ff[i] <= LPM_REG_RST;
      end
    end else if (gen_wr) begin
      gen_ff[idx] <= rb.wdata;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  unmapped_read_a: assert property (
    rb.rd_stb && !in_range |-> rd_data == LPM_REG_RST)
    else $error("unmapped address did not read zero");

  reg_store_a: assert property (
    gen_wr |=> gen_ff[$past(idx)] == $past(rb.wdata))
    else $error("register write was not stored");

  sda_timing_a: assert property (
    $changed(sda_oe) |-> $past(!scl_s_ff))
    else $error("data line changed while clock high");

  cmd_layout_a: assert property (
    rb.rd_stb && is_cmd |-> rd_data[7] && (rd_data[LPM_CMD_ALS_RDY] == rdy_ff[LPM_CH_ALS])
                            && (rd_data[LPM_CMD_RUN] == run_ff))
    else $error("command register read wrong");

  als_clear_a: assert property (
    rb.rd_stb && is_als && !done[LPM_CH_ALS] |=> !rdy_ff[LPM_CH_ALS])
    else $error("ambient ready not cleared by read");

  prox_clear_a: assert property (
    rb.rd_stb && is_prox && !done[LPM_CH_PROX] |=> !rdy_ff[LPM_CH_PROX])
    else $error("proximity ready not cleared by read");

  als_shot_a: assert property (
    os_start[LPM_CH_ALS] |=> os_ff[LPM_CH_ALS] && busy[LPM_CH_ALS])
    else $error("ambient one-shot did not start");

  prox_shot_a: assert property (
    os_start[LPM_CH_PROX] |=> os_ff[LPM_CH_PROX] && busy[LPM_CH_PROX] ##0 !done[LPM_CH_PROX])
    else $error("proximity one-shot did not start");

  both_shot_a: assert property (
    cmd_wr && !run_ff && !rb.wdata[LPM_CMD_RUN] && busy == 2'b00
    && rb.wdata[LPM_CMD_ALS_OS] && rb.wdata[LPM_CMD_PROX_OS] |=> busy == 2'b11)
    else $error("simultaneous conversions not started");

  shot_ignored_a: assert property (
    (run_ff || (cmd_wr && rb.wdata[LPM_CMD_RUN])) && os_ff == 2'b00 |=> os_ff == 2'b00)
    else $error("one-shot taken while running");

  int_drive_a: assert property (
    $rose(rdy_ff[LPM_CH_ALS]) || $rose(rdy_ff[LPM_CH_PROX]) |-> int_oe && !int_out)
    else $error("interrupt pin not pulled low");

  als_ready_a: assert property (
    done[LPM_CH_ALS] |=> rdy_ff[LPM_CH_ALS] && (als_res_ff == $past(als_result)))
    else $error("ambient flag and result not together");

  prox_ready_a: assert property (
    done[LPM_CH_PROX] |=> rdy_ff[LPM_CH_PROX] && (prox_res_ff == $past(prox_result)))
    else $error("proximity flag and result not together");

  id_read_a: assert property (
    rb.rd_stb && is_id |-> rd_data == LPM_ID_VALUE)
    else $error("identification register read wrong");

  cmd_flags_a: assert property (
    rb.rd_stb && is_cmd |-> (rd_data[LPM_CMD_PROX_RDY] == rdy_ff[LPM_CH_PROX])
                            && (rd_data[LPM_CMD_ALS_OS] == os_ff[LPM_CH_ALS])
                            && (rd_data[LPM_CMD_PROX_OS] == os_ff[LPM_CH_PROX]))
    else $error("command register flags read wrong");

  als_rdy_hold_a: assert property (
    rdy_ff[LPM_CH_ALS] && !(rb.rd_stb && is_als) |=> rdy_ff[LPM_CH_ALS])
    else $error("ambient ready lost without a read");

  prox_rdy_hold_a: assert property (
    rdy_ff[LPM_CH_PROX] && !(rb.rd_stb && is_prox) |=> rdy_ff[LPM_CH_PROX])
    else $error("proximity ready lost without a read");

  als_busy_a: assert property (
    os_ff[LPM_CH_ALS] |-> busy[LPM_CH_ALS] || done[LPM_CH_ALS])
    else $error("ambient one-shot bit set without conversion");

  prox_busy_a: assert property (
    os_ff[LPM_CH_PROX] |-> busy[LPM_CH_PROX] || done[LPM_CH_PROX])
    else $error("proximity one-shot bit set without conversion");

  als_hold_a: assert property (
    !done[LPM_CH_ALS] |=> $stable(als_res_ff))
    else $error("ambient result changed outside conversion end");

  prox_hold_a: assert property (
    !done[LPM_CH_PROX] |=> $stable(prox_res_ff))
    else $error("proximity result changed outside conversion end");

  per_store_a: assert property (
    cmd_wr |=> (per_en_ff[LPM_CH_ALS] == $past(rb.wdata[LPM_CMD_ALS_PER]))
               && (per_en_ff[LPM_CH_PROX] == $past(rb.wdata[LPM_CMD_PROX_PER])))
    else $error("periodic enables not stored");

  run_store_a: assert property (
    cmd_wr |=> run_ff == $past(rb.wdata[LPM_CMD_RUN]))
    else $error("run bit not stored");

  run_no_shot_a: assert property (
    run_ff |-> os_start == 2'b00)
    else $error("one-shot started while running");

  int_idle_a: assert property (
    rdy_ff == 2'b00 |-> !int_oe)
    else $error("interrupt pin pulled without a result");

  als_early_a: assert property (
    !rdy_ff[LPM_CH_ALS] && !done[LPM_CH_ALS] |=> !rdy_ff[LPM_CH_ALS])
    else $error("ambient ready raised before result");

  prox_early_a: assert property (
    !rdy_ff[LPM_CH_PROX] && !done[LPM_CH_PROX] |=> !rdy_ff[LPM_CH_PROX])
    else $error("proximity ready raised before result");

  both_shot_c: cover property (os_start == 2'b11);
  periodic_done_c: cover property (run_ff && done[LPM_CH_PROX]);
  ready_clear_c: cover property (rdy_ff[LPM_CH_ALS] ##1 rb.rd_stb && is_als);
  reg_write_c: cover property (gen_wr);
  shot_done_c: cover property (os_ff[LPM_CH_ALS] && done[LPM_CH_ALS]);
endmodule : lpm_measure_top

// *** testbench/lpm_host_model.sv ***
// serial bus master standing in for the host controller
`timescale 1ns/1ps
module lpm_host_model (
  input wire logic clk_sys,
  input wire logic sda_in,
  output logic scl_low,
  output logic sda_low
);
  localparam int QTR = 5;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (QTR) @(posedge clk_sys);
    #1;
  endtask : tick
  // start, also a repeated start with the clock low
  task automatic start();
    sda_low = 1'b0;
    tick();
    scl_low = 1'b0;
    tick();
    sda_low = 1'b1;
    tick();
    scl_low = 1'b1;
    tick();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl_low = 1'b0;
    tick();
    sda_low = 1'b0;
    tick();
  endtask : stop
  // one clock: 1 releases data to the pull-up, sample while clock is high
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    tick();
    scl_low = 1'b0;
    tick();
    s = sda_in;
    tick();
    scl_low = 1'b1;
    tick();
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  // last set means no acknowledge after the byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask : rd_byte
endmodule : lpm_host_model

// *** testbench/light_prox_measure_command_test.sv ***
// self-checking bench of the light and proximity measurement command block
`timescale 1ns/1ps
module light_prox_measure_command_test;
  import lpm_pkg::*;
  localparam int PER = 6000;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] als_result = 16'h0000;
  logic [15:0] prox_result = 16'h0000;
  logic scl_low, sda_low, sda_out, sda_oe, int_out, int_oe, als_conv, prox_conv;
  wire logic scl = ~scl_low;
  wire logic sda = ~(sda_low | sda_oe);
  wire logic int_pin = ~int_oe;
  int fails = 0;
  int num_checks = 0;
  int als_starts = 0;
  int prox_starts = 0;
  logic als_q = 1'b0;
  logic prox_q = 1'b0;
  logic [7:0] rd, wd, ex, cmd;
  logic ack;
  logic [7:0] bad_addr[3] = '{8'h28, 8'h66, 8'h08};
  logic [7:0] rw_addr[7] = '{8'h82, 8'h83, 8'h84, 8'h90, 8'h81, 8'h85, 8'h91};
  logic [7:0] os_cmd[3] = '{8'h10, 8'h08, 8'h18};

  always #4 clk_sys = ~clk_sys;

  lpm_measure_top #(.PERIOD_CYC(PER)) dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .int_out(int_out),
    .int_oe(int_oe),
    .als_result(als_result),
    .prox_result(prox_result),
    .als_conv(als_conv),
    .prox_conv(prox_conv)
  );

  lpm_host_model host (.clk_sys(clk_sys), .sda_in(sda), .scl_low(scl_low), .sda_low(sda_low));

  // counts conversion starts
  always @(posedge clk_sys) begin
    if (als_conv === 1'b1 && als_q === 1'b0) als_starts++;
    if (prox_conv === 1'b1 && prox_q === 1'b0) prox_starts++;
    als_q <= als_conv;
    prox_q <= prox_conv;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic k;
    host.start();
    host.wr_byte({LPM_DEV_ADDR, 1'b0}, k);
    check({7'h00, k}, 8'h01);
    host.wr_byte(a, k);
    host.wr_byte(d, k);
    host.stop();
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic k;
    host.start();
    host.wr_byte({LPM_DEV_ADDR, 1'b0}, k);
    host.wr_byte(a, k);
    host.start();
    host.wr_byte({LPM_DEV_ADDR, 1'b1}, k);
    check({7'h00, k}, 8'h01);
    host.rd_byte(1'b1, d);
    host.stop();
  endtask : reg_read

  task automatic wait_idle();
    int n = 0;
    while ((als_conv !== 1'b0 || prox_conv !== 1'b0) && n < 4000) begin
      idle(1);
      n++;
    end
    check({7'h00, als_conv | prox_conv}, 8'h00);
    // ready flags follow the end of conversion by one cycle
    idle(2);
  endtask : wait_idle

  task automatic complete_run();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    idle(12);
    nrst = 1'b1;
    idle(4);
    check({int_pin, int_out, sda_out, als_conv, prox_conv, 3'h0}, 8'h80);
    reg_read(8'h80, rd);
    check(rd, 8'h80);
    foreach (bad_addr[i]) begin
      host.start();
      host.wr_byte(bad_addr[i], ack);
      host.stop();
      check({7'h00, ack}, 8'h00);
    end
    $display("test address done");
    foreach (rw_addr[i]) begin
      wd = rw_addr[i] ^ 8'h5c;
      ex = (rw_addr[i] == 8'h81) ? LPM_ID_VALUE : (rw_addr[i] inside {8'h85, 8'h91}) ? 8'h00 : wd;
      reg_write(rw_addr[i], wd);
      reg_read(rw_addr[i], rd);
      check(rd, ex);
    end
    // burst read with master acknowledge: pointer steps per fetched byte
    host.start();
    host.wr_byte({LPM_DEV_ADDR, 1'b0}, ack);
    host.wr_byte(8'h82, ack);
    host.start();
    host.wr_byte({LPM_DEV_ADDR, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    host.rd_byte(1'b0, rd);
    check(rd, 8'h82 ^ 8'h5c);
    host.rd_byte(1'b1, rd);
    check(rd, 8'h83 ^ 8'h5c);
    host.stop();
    $display("test registers done");
    foreach (os_cmd[i]) begin
      cmd = os_cmd[i];
      als_result = 16'h1357 + 16'(i);
      prox_result = 16'hace0 - 16'(i);
      reg_write(8'h80, cmd);
      check({6'h00, als_conv, prox_conv}, {6'h00, cmd[4:3]});
      reg_read(8'h80, rd);
      check(rd, 8'h80 | cmd);
      wait_idle();
      check({7'h00, int_pin}, 8'h00);
      reg_read(8'h80, rd);
      check(rd, {1'b1, cmd[4:3], 5'h00});
      if (cmd[4]) begin
        reg_read(8'h86, rd);
        check(rd, als_result[7:0]);
        reg_read(8'h80, rd);
        check(rd, {2'b10, cmd[3], 5'h00});
        reg_read(8'h85, rd);
        check(rd, als_result[15:8]);
      end
      if (cmd[3]) begin
        reg_read(8'h87, rd);
        check(rd, prox_result[15:8]);
        reg_read(8'h80, rd);
        check(rd, 8'h80);
        reg_read(8'h88, rd);
        check(rd, prox_result[7:0]);
      end
      check({7'h00, int_pin}, 8'h01);
    end
    $display("test one-shot done");
    als_starts = 0;
    prox_starts = 0;
    reg_write(8'h80, 8'h01);
    idle(PER + 500);
    check(8'(als_starts + prox_starts), 8'h00);
    als_starts = 0;
    reg_write(8'h80, 8'h05);
    idle(2 * PER + 500);
    check(8'(als_starts), 8'h03);
    check(8'(prox_starts), 8'h00);
    als_starts = 0;
    prox_starts = 0;
    reg_write(8'h80, 8'h19);
    wait_idle();
    idle(PER);
    check(8'(als_starts + prox_starts), 8'h00);
    reg_read(8'h80, rd);
    check(rd & 8'h1f, 8'h01);
    als_starts = 0;
    prox_starts = 0;
    reg_write(8'h80, 8'h03);
    idle(PER + 500);
    check(8'(prox_starts), 8'h02);
    check(8'(als_starts), 8'h00);
    reg_write(8'h80, 8'h00);
    wait_idle();
    $display("test periodic done");
    complete_run();
  end

  initial begin
    repeat (95000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule : light_prox_measure_command_test
